// ===== src/mitp_pkg.sv
// Shared constants for the modulo interval timer with shared PWM pins.
package mitp_pkg;
  localparam int          DATA_W       = 9;
  localparam int          PIN_N        = 3;
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_MODULO   = 8'h04;
  localparam logic [7:0]  OFF_PWM0     = 8'h08;
  localparam logic [7:0]  OFF_PWM1     = 8'h0C;
  localparam logic [7:0]  OFF_COUNT    = 8'h10;
  localparam logic [7:0]  OFF_STATUS   = 8'h14;
  localparam logic [7:0]  OFF_CLEAR    = 8'h18;
  localparam logic [7:0]  OFF_ENABLE   = 8'h1C;
  localparam logic [7:0]  OFF_PORT     = 8'h20;
  localparam int          CTL_CLR_BIT  = 0;
  localparam int          CTL_RUN_BIT  = 1;
  localparam int          CTL_PWM_BIT  = 2;
  localparam int          CTL_SEL_BIT  = 3;
  localparam int          CTL_CLK_BIT  = 4;
  localparam int          CTL_EI_BIT   = 5;
  localparam logic [8:0]  PWM_RST      = 9'h1FF;
  localparam int          DIV_FAST     = 4;
  localparam int          DIV_SLOW     = 40;
  localparam int          PRE_W        = 16;
endpackage

// ===== src/mitp_timer.sv
// Modulo interval timer sharing its modulo register and pins with PWM.
`timescale 1ns/1ps
module mitp_timer #(
  parameter int DIV_FAST = mitp_pkg::DIV_FAST,
  parameter int DIV_SLOW = mitp_pkg::DIV_SLOW
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        watchdog_stack_reset,
  input  wire logic        clock_stop,
  input  wire logic        chip_enable_reset,
  input  wire logic        halt,
  output logic [2:0]       pin_out,
  output logic [2:0]       pin_oe,
  output logic [2:0]       pin_port_mode,
  output logic             interrupts_disabled_state,
  output logic             irq
);
  localparam int W = mitp_pkg::DATA_W;
  localparam int PW = mitp_pkg::PRE_W;

  logic          timer_run_flag_r;
  logic          timer_function_select_flag_r;
  logic          pwm_out_en_r;
  logic          clk_sel_r;
  logic [W-1:0]  pwm_data_r [mitp_pkg::PIN_N];
  logic [W-1:0]  cnt_r;
  logic [PW-1:0] pre_r;
  logic [W-1:0]  pwm_cnt_r;
  logic [2:0]    port_latch_r;
  logic          status_r;
  logic          enable_r;
  logic          ints_off_r;
  logic [2:0]    pin_oe_r;
  logic          pready_r;
  logic [31:0]   prdata_r;
  logic          pslverr_r;
  logic [2:0]    pin_out_r;
  logic [2:0]    pin_mode_r;
  logic          irq_r;

  // Bus decode.
  wire setup_acc = psel & penable & ~pready_r;
  wire wr_done   = psel & penable & pready_r & pwrite;
  wire hit_ctrl  = paddr == mitp_pkg::OFF_CTRL;
  wire hit_mod   = paddr == mitp_pkg::OFF_MODULO;
  wire hit_pwm0  = paddr == mitp_pkg::OFF_PWM0;
  wire hit_pwm1  = paddr == mitp_pkg::OFF_PWM1;
  wire hit_cnt   = paddr == mitp_pkg::OFF_COUNT;
  wire hit_stat  = paddr == mitp_pkg::OFF_STATUS;
  wire hit_clr   = paddr == mitp_pkg::OFF_CLEAR;
  wire hit_en    = paddr == mitp_pkg::OFF_ENABLE;
  wire hit_port  = paddr == mitp_pkg::OFF_PORT;
  wire mapped    = hit_ctrl | hit_mod | hit_pwm0 | hit_pwm1 | hit_cnt |
                   hit_stat | hit_clr | hit_en | hit_port;
  wire wr_ctrl   = wr_done & hit_ctrl;
  wire wr_clr    = wr_done & hit_clr;
  wire wr_en     = wr_done & hit_en;
  wire wr_port   = wr_done & hit_port;

  // Resets that restore power-on values without the bus reset.
  wire hard_rst  = watchdog_stack_reset;
  wire data_rst  = watchdog_stack_reset | clock_stop;

  wire [31:0] ctrl_rd = {26'h0, ~ints_off_r, clk_sel_r,
                         timer_function_select_flag_r, pwm_out_en_r,
                         timer_run_flag_r, 1'b0};
  wire [31:0] rd_mux =
    hit_ctrl ? ctrl_rd :
    hit_mod  ? {23'h0, pwm_data_r[2]} :
    hit_pwm0 ? {23'h0, pwm_data_r[0]} :
    hit_pwm1 ? {23'h0, pwm_data_r[1]} :
    hit_cnt  ? {23'h0, cnt_r} :
    hit_stat ? {31'h0, status_r} :
    hit_en   ? {31'h0, enable_r} :
    hit_port ? {29'h0, port_latch_r} : 32'h0000_0000;

  // Basic clock generation.
  wire [PW-1:0] div_end = clk_sel_r ? PW'(DIV_SLOW - 1) : PW'(DIV_FAST - 1);
  wire          tick    = pre_r == div_end;
  wire timer_on  = timer_function_select_flag_r & timer_run_flag_r;
  wire clr_req   = wr_ctrl & pwdata[mitp_pkg::CTL_CLR_BIT] &
                   timer_function_select_flag_r;
  wire match     = timer_on & tick & (cnt_r == pwm_data_r[2]);
  wire new_sel   = pwdata[mitp_pkg::CTL_CLK_BIT];
  // A stale prescaler phase would stretch the first period of a new clock.
  wire clk_change = wr_ctrl & (new_sel != clk_sel_r);

  wire port_mode = timer_function_select_flag_r | ~pwm_out_en_r;

  // APB slave: one wait state, answer registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup_acc;
      pslverr_r <= setup_acc & ~mapped;
    end
  end

  // Read data holds until the next read, so a slow master still sees it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_acc && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  // Run and select flags; chip-enable reset and halt leave them alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_run_flag_r             <= 1'b0;
      timer_function_select_flag_r <= 1'b0;
    end else if (data_rst) begin
      timer_run_flag_r             <= 1'b0;
      timer_function_select_flag_r <= 1'b0;
    end else if (wr_ctrl) begin
      timer_run_flag_r             <= pwdata[mitp_pkg::CTL_RUN_BIT];
      timer_function_select_flag_r <= pwdata[mitp_pkg::CTL_SEL_BIT];
    end
  end

  // Output enable and basic clock choice, reset alike.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out_en_r <= 1'b0;
      clk_sel_r    <= 1'b0;
    end else if (data_rst) begin
      pwm_out_en_r <= 1'b0;
      clk_sel_r    <= 1'b0;
    end else if (wr_ctrl) begin
      pwm_out_en_r <= pwdata[mitp_pkg::CTL_PWM_BIT];
      clk_sel_r    <= new_sel;
    end
  end

  // Data registers; data two doubles as the timer modulo register.
  // Sharing one word is the software's burden; no arbitration is done.
  genvar g;
  generate
    for (g = 0; g < mitp_pkg::PIN_N; g++) begin : g_data
      logic [7:0] my_off;
      assign my_off = (g == 0) ? mitp_pkg::OFF_PWM0 :
                      (g == 1) ? mitp_pkg::OFF_PWM1 : mitp_pkg::OFF_MODULO;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pwm_data_r[g] <= mitp_pkg::PWM_RST;
        end else if (data_rst) begin
          pwm_data_r[g] <= mitp_pkg::PWM_RST;
        end else if (wr_done && paddr == my_off) begin
          pwm_data_r[g] <= pwdata[W-1:0];
        end
      end
    end
  endgenerate

  // Prescaler restarts whenever a control write changes the basic clock choice.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (clk_change) begin
      pre_r <= '0;
    end else if (tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PW'(1);
    end
  end

  // Interval counter; halt and chip-enable reset do not disturb it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (hard_rst) begin
      cnt_r <= '0;
    end else if (clr_req) begin
      cnt_r <= '0;
    end else if (match) begin
      cnt_r <= '0;
    end else if (timer_on && tick) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  // PWM period counter runs off the same basic clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_r <= '0;
    end else if (tick) begin
      pwm_cnt_r <= pwm_cnt_r + W'(1);
    end
  end

  // Port latch keeps its value through clock stop.
  // Only a watchdog reset clears it, so software owns it otherwise.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_latch_r <= 3'h0;
    end else if (hard_rst) begin
      port_latch_r <= 3'h0;
    end else if (wr_port) begin
      port_latch_r <= pwdata[2:0];
    end
  end

  // Pins are registered so the pads never see decode glitches.
  generate
    for (g = 0; g < mitp_pkg::PIN_N; g++) begin : g_pin
      wire pwm_level = pwm_cnt_r < pwm_data_r[g];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_out_r[g]  <= 1'b0;
          pin_mode_r[g] <= 1'b1;
        end else if (data_rst) begin
          pin_out_r[g]  <= hard_rst ? 1'b0 : port_latch_r[g];
          pin_mode_r[g] <= 1'b1;
        end else if (port_mode) begin
          pin_out_r[g]  <= port_latch_r[g];
          pin_mode_r[g] <= 1'b1;
        end else begin
          pin_out_r[g]  <= pwm_level;
          pin_mode_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Interrupt decode.
  // Masking acts after the sticky bit, so status stays readable.
  wire stat_clr   = wr_clr & pwdata[0];
  wire ce_disable = chip_enable_reset & timer_function_select_flag_r;
  wire ei_write   = wr_ctrl & pwdata[mitp_pkg::CTL_EI_BIT];
  wire irq_nxt    = (status_r | match) & enable_r & ~ints_off_r;

  // Set wins over a clear in the same cycle, so no match is lost.
  // Sticky match.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 1'b0;
    end else if (match) begin
      status_r <= 1'b1;
    end else if (stat_clr) begin
      status_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r <= 1'b0;
    end else if (wr_en) begin
      enable_r <= pwdata[0];
    end
  end

  // A chip-enable reset beats a software clear in the same cycle.
  // Disable on chip-enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ints_off_r <= 1'b0;
    end else if (ce_disable) begin
      ints_off_r <= 1'b1;
    end else if (hard_rst || ei_write) begin
      ints_off_r <= 1'b0;
    end
  end

  // The match term lets the request rise one cycle after the event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Pins drive in both modes; only the source of the level changes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_r <= 3'h7;
    end else begin
      pin_oe_r <= 3'h7;
    end
  end

  // Halt is accepted but changes nothing: all state keeps running.
  // Retain on halt.
  wire unused_halt = halt;

  assign pready                    = pready_r;
  assign prdata                    = prdata_r;
  assign pslverr                   = pslverr_r;
  assign pin_out                   = pin_out_r;
  assign pin_oe                    = pin_oe_r;
  assign pin_port_mode             = pin_mode_r;
  assign interrupts_disabled_state = ints_off_r;
  assign irq                       = irq_r;
endmodule // mitp_timer

// ===== bench/mitp_timer_assertions.sv
// Port assertions for the modulo interval timer.
`timescale 1ns/1ps
module mitp_timer_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        watchdog_stack_reset,
  input wire logic        clock_stop,
  input wire logic        chip_enable_reset,
  input wire logic [2:0]  pin_out,
  input wire logic [2:0]  pin_port_mode,
  input wire logic        interrupts_disabled_state,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Tracks the timer select flag, since the checker cannot see inside.
  logic sel_r;
  wire  ctl_wr = psel && penable && pready && pwrite && paddr == 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sel_r <= 1'b0;
    else if (watchdog_stack_reset || clock_stop) sel_r <= 1'b0;
    else if (ctl_wr) sel_r <= pwdata[3];
  end
  property p_port_sel;
    sel_r && $past(sel_r) |-> pin_port_mode == 3'h7;
  endproperty
  a_port_sel: assert property (p_port_sel) else $error("pins not in port");
  property p_wdt_pins;
    watchdog_stack_reset |-> ##[1:2] (pin_out == 3'h0 && pin_port_mode == 3'h7);
  endproperty
  a_wdt_pins: assert property (p_wdt_pins) else $error("pins after wdt");
  property p_cs_port;
    clock_stop |-> ##[1:2] pin_port_mode == 3'h7;
  endproperty
  a_cs_port: assert property (p_cs_port) else $error("port after stop");
  property p_cs_latch;
    clock_stop && pin_port_mode == 3'h7 |=> $stable(pin_out);
  endproperty
  a_cs_latch: assert property (p_cs_latch) else $error("latch lost");
  property p_ce_di;
    chip_enable_reset && sel_r |=> interrupts_disabled_state;
  endproperty
  a_ce_di: assert property (p_ce_di) else $error("no disable state");
  property p_ce_keep;
    chip_enable_reset |=> $stable(pin_port_mode);
  endproperty
  a_ce_keep: assert property (p_ce_keep) else $error("pins moved");
  property p_di_mask;
    interrupts_disabled_state && $past(interrupts_disabled_state) |-> !irq;
  endproperty
  a_di_mask: assert property (p_di_mask) else $error("irq while masked");
  property p_one_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late");
  property p_err_rdy;
    pslverr |-> pready ##1 !pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("stray pslverr");
  c_irq: cover property ($rose(irq));
  c_ce: cover property (chip_enable_reset && sel_r);
  c_err: cover property (pslverr);
  c_pwm: cover property (pin_port_mode == 3'h0);
endmodule // mitp_timer_chk
bind mitp_timer mitp_timer_chk i_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .watchdog_stack_reset,
  .clock_stop, .chip_enable_reset, .pin_out, .pin_port_mode,
  .interrupts_disabled_state, .irq);

// ===== bench/test_modulo_interval_timer_pwm_shared.sv
// Self-checking bench for the modulo interval timer.
`timescale 1ns/1ps
module test_modulo_interval_timer_pwm_shared;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdt, d;
  logic        pready, pslverr, err, wdr = 0, cs = 0, cer = 0, halt = 0;
  logic [2:0]  pin_out, pin_oe, pin_port_mode;
  logic        ints_off, irq;
  int          bad_count = 0, num_checks = 0;
  logic [7:0]  ra [7] = '{8'h08, 8'h0C, 8'h04, 8'h20, 8'h1C, 8'h10, 8'h18};
  logic [31:0] rw [7] = '{32'hFFFF_FFFF, 32'h155, 32'h3, 32'h5, 32'h1,
                          32'h7, 32'h1};
  logic [31:0] rx [7] = '{32'h1FF, 32'h155, 32'h3, 32'h5, 32'h1, 32'h0,
                          32'h0};
  always #2.5 pclk = ~pclk;
  mitp_timer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .watchdog_stack_reset(wdr),
    .clock_stop(cs), .chip_enable_reset(cer), .halt, .pin_out, .pin_oe,
    .pin_port_mode, .interrupts_disabled_state(ints_off), .irq);
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdt = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task idle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    idle(1);
    check(pin_out, 3'h0);
    check(pin_port_mode, 3'h7);
    check(pin_oe, 3'h7);
    apb(1'b0, 8'h04, 32'h0);
    check(rdt, 32'h0000_01FF);
    // Rows cover the PWM data words and the modulo word, then port, enable, count and clear.
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ra[i], rw[i]);
      apb(1'b0, ra[i], 32'h0);
      check(rdt, rx[i]);
    end
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1'b1);
    // Halt held high must not stop the interval count.
    halt <= 1'b1;
    apb(1'b1, 8'h00, 32'hA);
    for (int n = 0; n < 100 && irq !== 1'b1; n++) @(posedge pclk);
    check(irq, 1'b1);
    check(pin_port_mode, 3'h7);
    apb(1'b0, 8'h10, 32'h0);
    check(rdt & 32'hFFFF_FFFC, 32'h0);
    apb(1'b1, 8'h00, 32'h8);
    apb(1'b1, 8'h18, 32'h1);
    idle(2);
    check(irq, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    d = rdt;
    idle(20);
    apb(1'b0, 8'h10, 32'h0);
    check(rdt, d);
    apb(1'b1, 8'h00, 32'h9);
    apb(1'b0, 8'h10, 32'h0);
    check(rdt, 32'h0);
    apb(1'b1, 8'h00, 32'h2);
    idle(40);
    apb(1'b0, 8'h10, 32'h0);
    check(rdt, 32'h0);
    apb(1'b1, 8'h00, 32'hA);
    // A chip-enable reset in timer mode sets the disabled state and masks the interrupt.
    @(posedge pclk) cer <= 1'b1;
    @(posedge pclk) cer <= 1'b0;
    idle(2);
    check(ints_off, 1'b1);
    idle(40);
    check(irq, 1'b0);
    apb(1'b1, 8'h00, 32'h28);
    halt <= 1'b0;
    @(posedge pclk) cs <= 1'b1;
    @(posedge pclk) cs <= 1'b0;
    idle(3);
    check(pin_port_mode, 3'h7);
    check(pin_out, 3'h5);
    apb(1'b0, 8'h04, 32'h0);
    check(rdt, 32'h0000_01FF);
    @(posedge pclk) wdr <= 1'b1;
    @(posedge pclk) wdr <= 1'b0;
    idle(3);
    check(pin_out, 3'h0);
    check(pin_port_mode, 3'h7);
    apb(1'b0, 8'h08, 32'h0);
    check(rdt, 32'h0000_01FF);
    // PWM mode: pins leave port mode and keep it through chip-enable reset.
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'h4);
    idle(2);
    check(pin_port_mode, 3'h0);
    check(pin_out[0], 1'b0);
    @(posedge pclk) cer <= 1'b1;
    @(posedge pclk) cer <= 1'b0;
    idle(2);
    check(pin_port_mode, 3'h0);
    check(ints_off, 1'b0);
    check(pin_oe, 3'h7);
    give_verdict;
  end
endmodule // test_modulo_interval_timer_pwm_shared
